// ==== include/vrc_defs.vh ====
// constants for the voice recorder command port
`ifndef VRC_DEFS_VH
`define VRC_DEFS_VH

// master clock rate in MHz; times below are in us or ms
`define VRC_CLK_MHZ       24'd25
// cycles per millisecond; every count below stays inside 24 bits
`define VRC_CYC_PER_MS    (24'd1000 * `VRC_CLK_MHZ)

// command codes, first nibble of each command
`define VRC_OP_NOP        4'h0
`define VRC_OP_PAUSE      4'h1
`define VRC_OP_PLAY       4'h2
`define VRC_OP_CAPTURE    4'h3
`define VRC_OP_START      4'h4
`define VRC_OP_STOP       4'h5
`define VRC_OP_ERASE      4'h6
`define VRC_OP_RATE       4'h7
`define VRC_OP_VOICE      4'h8
`define VRC_OP_RAMP       4'h9
`define VRC_OP_TRACK      4'hA
`define VRC_OP_BLOCK_WRITE_CMD      4'hB
`define VRC_OP_BLOCK_READ_CMD      4'hC
`define VRC_OP_PTRWR      4'hD
`define VRC_OP_PTRRD      4'hE
`define VRC_OP_OUTSIDE    4'hF

// status nibble field positions
`define VRC_ST_BUSY       0
`define VRC_ST_OUTSIDE    1
`define VRC_ST_RAMPING    2

// pointer length in nibbles (2nd through 11th)
`define VRC_PTR_NIBS      4'hA

// times
`define VRC_T_ERASE_ALL_MS  24'd550
`define VRC_T_ERASE_ONE_MS  24'd70
`define VRC_T_CMD_US        24'd16
`define VRC_T_PTR_NIB_US    24'd16
`define VRC_T_PTRRD_US      24'd270
`define VRC_T_DATA_RD_US    24'd50
`define VRC_T_RAMP_UP_MS    24'd64
`define VRC_T_RAMP_DN_MS    24'd256
`define VRC_T_ACT_HIGH_US   24'd31
`define VRC_T_ACT_LOW_US    24'd94

// cycle counts
`define VRC_C_ERASE_ALL  (`VRC_T_ERASE_ALL_MS * `VRC_CYC_PER_MS)
`define VRC_C_ERASE_ONE  (`VRC_T_ERASE_ONE_MS * `VRC_CYC_PER_MS)
`define VRC_C_CMD        (`VRC_T_CMD_US * `VRC_CLK_MHZ)
`define VRC_C_PTR_NIB    (`VRC_T_PTR_NIB_US * `VRC_CLK_MHZ)
`define VRC_C_PTRRD      (`VRC_T_PTRRD_US * `VRC_CLK_MHZ)
`define VRC_C_DATA_RD    (`VRC_T_DATA_RD_US * `VRC_CLK_MHZ)
`define VRC_C_ACT_HIGH   (`VRC_T_ACT_HIGH_US * `VRC_CLK_MHZ)
`define VRC_C_ACT_LOW    (`VRC_T_ACT_LOW_US * `VRC_CLK_MHZ)
// ramp spans 128 steps from ground to half supply
`define VRC_RAMP_STEPS   24'd128
`define VRC_RAMP_MID     8'h80
`define VRC_C_RAMP_UP  (`VRC_T_RAMP_UP_MS*`VRC_CYC_PER_MS/`VRC_RAMP_STEPS)
`define VRC_C_RAMP_DN  (`VRC_T_RAMP_DN_MS*`VRC_CYC_PER_MS/`VRC_RAMP_STEPS)

`endif

// ==== hw/vrc_ramp.v ====
// output dc level ramp generator
`timescale 1ns/1ns
`include "vrc_defs.vh"

module vrc_ramp #(
    parameter [23:0] STEP_UP = `VRC_C_RAMP_UP,
    parameter [23:0] STEP_DN = `VRC_C_RAMP_DN
) (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire       start,
    input  wire       rise,
    output reg  [7:0] dc_level,
    output wire       ramping
);

    reg [23:0] step_q;
    reg        rise_q;
    reg        run_q;

    assign ramping = run_q;

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            step_q   <= 24'h000000;
            rise_q   <= 1'b0;
            run_q    <= 1'b0;
            dc_level <= 8'h00;
        end else if (start) begin
            // first step one cycle after the command, well inside 16 us
            step_q <= 24'h000000;
            rise_q <= rise;
            run_q  <= 1'b1;
        end else if (run_q) begin
            if (step_q != 24'h000000) begin
                step_q <= step_q - 24'h000001;
            end else if (rise_q && dc_level != `VRC_RAMP_MID) begin
                dc_level <= dc_level + 8'h01;
                step_q   <= STEP_UP - 24'h000001;
            end else if (!rise_q && dc_level != 8'h00) begin
                dc_level <= dc_level - 8'h01;
                step_q   <= STEP_DN - 24'h000001;
            end else begin
                run_q <= 1'b0;
            end
        end
    end

endmodule // vrc_ramp

// ==== hw/vrc_cmd_port.v ====
// host nibble command port of the voice recorder
// Contract
// - ramp starts within 16 us of command
// - ramp up 64 ms, down 256 ms
// - ramp command nibble sets playback level
// - activity output rises within 330 us
// - outside transfer ends within 250 us of stop
// - simple commands are one nibble
// - rate, voice, ramp take two nibbles
// - track and block write take three
// - block read returns entry named by second nibble
// - pointer read returns ten nibbles
`timescale 1ns/1ns
`include "vrc_defs.vh"
module vrc_cmd_port #(
    parameter [23:0] ERASE_ALL_CYC = `VRC_C_ERASE_ALL,
    parameter [23:0] ERASE_ONE_CYC = `VRC_C_ERASE_ONE,
    parameter [23:0] PTRRD_CYC     = `VRC_C_PTRRD,
    parameter [23:0] RAMP_UP_CYC   = `VRC_C_RAMP_UP,
    parameter [23:0] RAMP_DN_CYC   = `VRC_C_RAMP_DN
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        wr_n,
    input  wire        rd_n,
    input  wire [3:0]  host_din,
    output reg  [3:0]  host_dout,
    output wire        host_doe,
    output wire        busy,
    output reg         activity_flag,
    input  wire [3:0]  adpcm_in,
    output reg  [3:0]  adpcm_out,
    output reg         adpcm_stb,
    output reg         cmd_stb,
    output reg  [3:0]  cmd_code,
    output reg  [7:0]  cmd_arg,
    output reg  [39:0] ptr_addr,
    output reg  [3:0]  play_level,
    output wire [7:0]  dc_level,
    output reg         outside_done
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ARGS = 3'd1;
    localparam [2:0] ST_PTRW = 3'd2;
    localparam [2:0] ST_PTRR = 3'd3;
    localparam [2:0] ST_BLKR = 3'd4;
    localparam [23:0] CMD_CYC  = `VRC_C_CMD;
    localparam [23:0] NIB_CYC  = `VRC_C_PTR_NIB;
    localparam [23:0] DRD_CYC  = `VRC_C_DATA_RD;
    localparam [23:0] HIGH_CYC = `VRC_C_ACT_HIGH;
    localparam [23:0] LOW_CYC  = `VRC_C_ACT_LOW;
    // extra nibbles that follow each first nibble other than pointer write
    function [1:0] arg_count;
        input [3:0] op;
        begin
            case (op)
                `VRC_OP_RATE, `VRC_OP_VOICE, `VRC_OP_RAMP,
                `VRC_OP_BLOCK_READ_CMD:                 arg_count = 2'd1;
                `VRC_OP_TRACK, `VRC_OP_BLOCK_WRITE_CMD:  arg_count = 2'd2;
                default:                       arg_count = 2'd0;
            endcase
        end
    endfunction
    reg [2:0]  state_q;
    reg        wr_n_q;
    reg        rd_n_q;
    reg [3:0]  op_q;
    reg [1:0]  left_q;
    reg [3:0]  arg1_q;
    reg [3:0]  nib_q;
    reg [23:0] busy_q;
    reg        phrase_sel_q;
    reg        rec_mode_q;
    reg        outside_q;
    reg [11:0] act_cnt_q;
    reg [3:0]  rec_nib_q;
    reg [3:0]  blk_idx_q;
    reg [3:0]  blk_mem [0:15];
    reg        ramp_go;
    wire       ramping;
    wire wr_done = wr_n & ~wr_n_q;
    wire rd_done = rd_n & ~rd_n_q;
    wire [3:0] status = {1'b0, ramping, outside_q, busy};
    assign busy     = (busy_q != 24'h000000);
    assign host_doe = ~rd_n;
    ////////////////////////////////////////////////////////////////////////
    // read data; a read pulse cannot report busy inside pointer/block reads
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            host_dout <= 4'h0;
        end else if (outside_q && rec_mode_q) begin
            host_dout <= rec_nib_q;
        end else if (state_q == ST_PTRR) begin
            host_dout <= ptr_addr[nib_q*4 +: 4];
        end else if (state_q == ST_BLKR) begin
            host_dout <= blk_mem[blk_idx_q];
        end else begin
            host_dout <= status;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q      <= ST_IDLE;
            wr_n_q       <= 1'b1;
            rd_n_q       <= 1'b1;
            op_q         <= 4'h0;
            left_q       <= 2'd0;
            arg1_q       <= 4'h0;
            nib_q        <= 4'h0;
            busy_q       <= 24'h000000;
            phrase_sel_q <= 1'b0;
            rec_mode_q   <= 1'b0;
            cmd_stb      <= 1'b0;
            cmd_code     <= 4'h0;
            cmd_arg      <= 8'h00;
            ptr_addr     <= 40'h0000000000;
            play_level   <= 4'h0;
            blk_idx_q    <= 4'h0;
            ramp_go      <= 1'b0;
        end else begin
            wr_n_q  <= wr_n;
            rd_n_q  <= rd_n;
            cmd_stb <= 1'b0;
            ramp_go <= 1'b0;
            if (busy) begin
                busy_q <= busy_q - 24'h000001;
            end
            case (state_q)
            ST_IDLE: begin
                if (wr_done && !(outside_q && !rec_mode_q &&
                                 host_din != `VRC_OP_STOP)) begin
                    op_q   <= host_din;
                    left_q <= arg_count(host_din);
                    nib_q  <= 4'h0;
                    busy_q <= CMD_CYC;
                    if (host_din == `VRC_OP_PTRWR) begin
                        state_q <= ST_PTRW;
                    end else if (host_din == `VRC_OP_PTRRD) begin
                        busy_q  <= PTRRD_CYC;
                        state_q <= ST_PTRR;
                    end else if (arg_count(host_din) != 2'd0) begin
                        state_q <= ST_ARGS;
                    end else begin
                        cmd_stb  <= 1'b1;
                        cmd_code <= host_din;
                        cmd_arg  <= 8'h00;
                        if (host_din == `VRC_OP_ERASE) begin
                            busy_q <= phrase_sel_q ? ERASE_ONE_CYC
                                                   : ERASE_ALL_CYC;
                        end
                        if (host_din == `VRC_OP_CAPTURE) begin
                            rec_mode_q <= 1'b1;
                        end
                        if (host_din == `VRC_OP_PLAY) begin
                            rec_mode_q <= 1'b0;
                        end
                    end
                end
            end
            ST_ARGS: begin
                if (wr_done) begin
                    left_q <= left_q - 2'd1;
                    arg1_q <= host_din;
                    busy_q <= CMD_CYC;
                    if (op_q == `VRC_OP_BLOCK_READ_CMD) begin
                        blk_idx_q <= host_din;
                        busy_q    <= DRD_CYC;
                        state_q   <= ST_BLKR;
                    end else if (left_q == 2'd1) begin
                        state_q  <= ST_IDLE;
                        cmd_stb  <= 1'b1;
                        cmd_code <= op_q;
                        if (arg_count(op_q) == 2'd2) begin
                            cmd_arg <= {arg1_q, host_din};
                        end else begin
                            cmd_arg <= {4'h0, host_din};
                        end
                        if (op_q == `VRC_OP_RAMP) begin
                            play_level <= host_din;
                            ramp_go    <= 1'b1;
                        end
                        if (op_q == `VRC_OP_TRACK) begin
                            phrase_sel_q <= 1'b1;
                        end
                        if (op_q == `VRC_OP_BLOCK_WRITE_CMD) begin
                            blk_idx_q <= arg1_q;
                        end
                    end
                end
            end
            ST_PTRW: begin
                if (wr_done) begin
                    ptr_addr[nib_q*4 +: 4] <= host_din;
                    busy_q <= NIB_CYC;
                    nib_q  <= nib_q + 4'h1;
                    if (nib_q == `VRC_PTR_NIBS - 4'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
            end
            ST_PTRR: begin
                if (rd_done) begin
                    busy_q <= DRD_CYC;
                    nib_q  <= nib_q + 4'h1;
                    if (nib_q == `VRC_PTR_NIBS - 4'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
            end
            ST_BLKR: begin
                if (rd_done) begin
                    state_q <= ST_IDLE;
                end
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end
    // block store, written by the third nibble of a block write
    always @(posedge ref_clk) begin
        if (state_q == ST_ARGS && wr_done && op_q == `VRC_OP_BLOCK_WRITE_CMD &&
            left_q == 2'd1) begin
            blk_mem[arg1_q] <= host_din;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // outside data transfer paced by the activity output
    wire ext_start = state_q == ST_IDLE && wr_done && !outside_q &&
                     host_din == `VRC_OP_OUTSIDE;
    wire ext_stop  = state_q == ST_IDLE && wr_done && outside_q &&
                     host_din == `VRC_OP_STOP;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            outside_q     <= 1'b0;
            activity_flag <= 1'b0;
            act_cnt_q     <= 12'h000;
            rec_nib_q     <= 4'h0;
            adpcm_out     <= 4'h0;
            adpcm_stb     <= 1'b0;
            outside_done  <= 1'b0;
        end else begin
            adpcm_stb    <= 1'b0;
            outside_done <= 1'b0;
            if (ext_start) begin
                // one low phase before the first rise: 94 us, under 330 us
                outside_q <= 1'b1;
                act_cnt_q <= LOW_CYC[11:0] - 12'h001;
            end else if (ext_stop) begin
                // stop ends the transfer at once, well inside 250 us
                outside_q     <= 1'b0;
                activity_flag <= 1'b0;
                outside_done  <= 1'b1;
            end else if (outside_q) begin
                if (act_cnt_q != 12'h000) begin
                    act_cnt_q <= act_cnt_q - 12'h001;
                end else if (activity_flag) begin
                    activity_flag <= 1'b0;
                    act_cnt_q     <= LOW_CYC[11:0] - 12'h001;
                end else begin
                    activity_flag <= 1'b1;
                    act_cnt_q     <= HIGH_CYC[11:0] - 12'h001;
                    rec_nib_q     <= adpcm_in;
                end
                if (!rec_mode_q && wr_done &&
                    host_din != `VRC_OP_STOP) begin
                    adpcm_out <= host_din;
                    adpcm_stb <= 1'b1;
                end
            end
        end
    end
    vrc_ramp #(
        .STEP_UP (RAMP_UP_CYC),
        .STEP_DN (RAMP_DN_CYC)
    ) u_ramp (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .start    (ramp_go),
        .rise     (play_level != 4'h0),
        .dc_level (dc_level),
        .ramping  (ramping)
    );
endmodule // vrc_cmd_port

// ==== test/vrc_cmd_port_monitor.sv ====
// assertion checker for the host command port
`timescale 1ns/1ns
`include "vrc_defs.vh"
module vrc_cmd_port_monitor (
    input wire       ref_clk,
    input wire       rstn,
    input wire       wr_n,
    input wire       rd_n,
    input wire       host_doe,
    input wire       busy,
    input wire       activity_flag,
    input wire       cmd_stb,
    input wire [3:0] cmd_code,
    input wire [7:0] cmd_arg,
    input wire [3:0] play_level,
    input wire [7:0] dc_level,
    input wire       outside_done
);
    reg        wr_q;
    reg [13:0] wait_q;
    // counts the idle cycles from an outside command to the first rise
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= 1'b1;
            wait_q <= 14'h0000;
        end else begin
            wr_q <= wr_n;
            if (cmd_stb && cmd_code == `VRC_OP_OUTSIDE)
                wait_q <= 14'h0001;
            else if (activity_flag)
                wait_q <= 14'h0000;
            else if (wait_q != 14'h0000)
                wait_q <= wait_q + 14'h0001;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    property p_doe;
        host_doe == !rd_n;
    endproperty
    a_doe: assert property (p_doe)
        else $error("bus drive does not follow read strobe");
    // writes while activity is high are excluded, as outside data writes do not start a wait
    property p_take;
        wr_n && !wr_q && !activity_flag |=> busy;
    endproperty
    a_take: assert property (p_take)
        else $error("written nibble did not raise busy");
    property p_stb;
        cmd_stb |=> !cmd_stb;
    endproperty
    a_stb: assert property (p_stb)
        else $error("command strobe longer than one cycle");
    property p_arg1;
        cmd_stb && (cmd_code <= `VRC_OP_ERASE ||
            cmd_code == `VRC_OP_OUTSIDE) |-> cmd_arg == 8'h00;
    endproperty
    a_arg1: assert property (p_arg1)
        else $error("single nibble command carries arguments");
    property p_arg2;
        cmd_stb && cmd_code >= `VRC_OP_RATE &&
            cmd_code <= `VRC_OP_RAMP |-> cmd_arg[7:4] == 4'h0;
    endproperty
    a_arg2: assert property (p_arg2)
        else $error("two nibble command carries a third");
    property p_lvl;
        cmd_stb && cmd_code == `VRC_OP_RAMP |->
            ##[0:1] play_level == cmd_arg[3:0];
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("playback level not taken from ramp command");
    property p_go;
        cmd_stb && cmd_code == `VRC_OP_RAMP && cmd_arg[3:0] != 4'h0 &&
            dc_level == 8'h00 |-> ##[1:400] dc_level != 8'h00;
    endproperty
    a_go: assert property (p_go)
        else $error("ramp did not start in time");
    property p_step;
        $changed(dc_level) |-> dc_level <= 8'h80 &&
            (dc_level == $past(dc_level) + 8'h01 ||
            dc_level + 8'h01 == $past(dc_level));
    endproperty
    a_step: assert property (p_step)
        else $error("output level jumped");
    property p_act;
        wait_q <= 14'h203A;
    endproperty
    a_act: assert property (p_act)
        else $error("activity output late after outside command");
    property p_stop;
        outside_done |-> ##[0:1] !activity_flag;
    endproperty
    a_stop: assert property (p_stop)
        else $error("activity still high after transfer end");
endmodule // vrc_cmd_port_monitor

bind vrc_cmd_port vrc_cmd_port_monitor mon (
    .ref_clk(ref_clk), .rstn(rstn), .wr_n(wr_n), .rd_n(rd_n),
    .host_doe(host_doe), .busy(busy), .activity_flag(activity_flag),
    .cmd_stb(cmd_stb), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
    .play_level(play_level), .dc_level(dc_level),
    .outside_done(outside_done)
);

// ==== test/vrc_host.sv ====
// host microcontroller model driving the nibble port
`timescale 1ns/1ns
module vrc_host (
    input  wire       ref_clk,
    input  wire       busy,
    input  wire [3:0] host_dout,
    output reg        wr_n,
    output reg        rd_n,
    output reg  [3:0] host_din
);
    initial begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        host_din = 4'h5;
    end
    ////////////////////////////////////////
    // data lines hold the nibble one cycle past the strobe release, then show the inverse
    task wr(input [3:0] nib);
        begin
            @(posedge ref_clk);
            wr_n <= 1'b0;
            host_din <= nib;
            @(posedge ref_clk);
            wr_n <= 1'b1;
            @(posedge ref_clk);
            host_din <= ~nib;
        end
    endtask
    task rd(output [3:0] v);
        begin
            @(posedge ref_clk);
            rd_n <= 1'b0;
            repeat (3) @(posedge ref_clk);
            v = host_dout;
            rd_n <= 1'b1;
        end
    endtask
    // busy pin rather than status polling, reads cannot poll it
    task idle;
        integer n;
        begin
            n = 0;
            repeat (2) @(posedge ref_clk);
            while (busy !== 1'b0 && n < 70000) begin
                @(posedge ref_clk);
                n = n + 1;
            end
        end
    endtask
endmodule // vrc_host

// ==== test/tb_vrc_cmd_port.sv ====
// self-checking bench for the voice recorder command port
`timescale 1ns/1ns
`include "vrc_defs.vh"
module tb_vrc_cmd_port;
    reg         ref_clk = 1'b0;
    reg         rstn = 1'b0;
    reg  [3:0]  adpcm_in = 4'hC;
    wire        wr_n, rd_n, host_doe, busy, activity_flag;
    wire        adpcm_stb, cmd_stb, outside_done;
    wire [3:0]  host_din, host_dout, adpcm_out, cmd_code, play_level;
    wire [7:0]  cmd_arg, dc_level;
    wire [39:0] ptr_addr;
    reg  [27:0] rows [0:10];
    reg  [27:0] r;
    reg  [3:0]  v;
    integer     i, n, cyc = 0, fails = 0, total_checks = 0;
    always #20 ref_clk = ~ref_clk;
    // short waits keep the run brief; expectations scale with them
    vrc_cmd_port #(.ERASE_ALL_CYC(24'h00003C), .ERASE_ONE_CYC(24'h00001E),
        .RAMP_UP_CYC(24'h000014),
        .RAMP_DN_CYC(24'h000028)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .wr_n(wr_n), .rd_n(rd_n),
        .host_din(host_din), .host_dout(host_dout), .host_doe(host_doe),
        .busy(busy), .activity_flag(activity_flag), .adpcm_in(adpcm_in),
        .adpcm_out(adpcm_out), .adpcm_stb(adpcm_stb), .cmd_stb(cmd_stb),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg), .ptr_addr(ptr_addr),
        .play_level(play_level), .dc_level(dc_level),
        .outside_done(outside_done));
    vrc_host host (.ref_clk(ref_clk), .busy(busy), .host_dout(host_dout),
        .wr_n(wr_n), .rd_n(rd_n), .host_din(host_din));
    ////////////////////////////////////////
    task check(input [39:0] seen, input [39:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    function cond(input integer k);
        case (k)
            0: cond = busy === 1'b1;
            1: cond = dc_level !== 8'h80;
            2: cond = dc_level !== 8'h00;
            3: cond = activity_flag !== 1'b1;
            default: cond = outside_done !== 1'b1;
        endcase
    endfunction
    task span(input integer k, output integer c);
        begin
            c = 0;
            #1;
            while (cond(k) && c < 9000) begin
                @(posedge ref_clk);
                #1;
                c = c + 1;
            end
        end
    endtask
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            fails = fails + 1;
            print_verdict;
        end
    end
    ////////////////////////////////////////
    initial begin
        // count, nibbles one to three, then expected code and argument
        rows[0] = 28'h1000000;
        rows[1] = 28'h1100100;
        rows[2] = 28'h1200200;
        rows[3] = 28'h1300300;
        rows[4] = 28'h1400400;
        rows[5] = 28'h1500500;
        rows[6] = 28'h2720702;
        rows[7] = 28'h2850805;
        rows[8] = 28'h2900900;
        rows[9] = 28'h3A14A14;
        rows[10] = 28'h3B35B35;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        for (i = 0; i < 11; i = i + 1) begin
            r = rows[i];
            host.idle;
            host.wr(r[23:20]);
            if (r[27:24] > 4'h1) begin
                host.idle;
                host.wr(r[19:16]);
            end
            if (r[27:24] > 4'h2) begin
                host.idle;
                host.wr(r[15:12]);
            end
            #1;
            check(cmd_stb, 1'b1);
            check({cmd_code, cmd_arg}, r[11:0]);
        end
        $display("command table done");
        host.idle;
        host.rd(v);
        check(v, 4'h0);
        host.wr(`VRC_OP_BLOCK_READ_CMD);
        host.idle;
        host.wr(4'h3);
        host.idle;
        host.rd(v);
        check(v, 4'h5);
        host.idle;
        host.wr(`VRC_OP_PTRWR);
        for (i = 1; i < 11; i = i + 1) begin
            host.idle;
            host.wr(i[3:0]);
        end
        host.idle;
        check(ptr_addr, 40'hA987654321);
        host.wr(`VRC_OP_PTRRD);
        for (i = 1; i < 11; i = i + 1) begin
            host.idle;
            host.rd(v);
            check(v, i[3:0]);
        end
        $display("block and pointer done");
        host.idle;
        host.wr(`VRC_OP_RAMP);
        host.idle;
        host.wr(4'h3);
        span(1, n);
        check(n > 2500 && n < 2600, 1'b1);
        check(play_level, 4'h3);
        host.wr(`VRC_OP_RAMP);
        host.idle;
        host.wr(4'h0);
        span(2, n);
        check(n > 5080 && n < 5160, 1'b1);
        $display("ramp done");
        host.idle;
        host.wr(`VRC_OP_CAPTURE);
        adpcm_in <= 4'h6;
        host.idle;
        host.wr(`VRC_OP_OUTSIDE);
        span(3, n);
        check(n < 8250, 1'b1);
        host.rd(v);
        check(v, 4'h6);
        host.wr(`VRC_OP_STOP);
        span(4, n);
        check(n < 6250 && activity_flag === 1'b0, 1'b1);
        host.idle;
        host.wr(`VRC_OP_PLAY);
        host.idle;
        host.wr(`VRC_OP_OUTSIDE);
        span(3, n);
        host.wr(4'h9);
        #1;
        check(adpcm_stb, 1'b1);
        repeat (400) @(posedge ref_clk);
        check(adpcm_out, 4'h9);
        host.wr(`VRC_OP_STOP);
        span(4, n);
        check(n < 6250, 1'b1);
        $display("outside transfer done");
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({busy, cmd_code, dc_level}, 13'h0000);
        @(posedge ref_clk);
        rstn <= 1'b1;
        host.idle;
        host.wr(`VRC_OP_ERASE);
        span(0, n);
        check(n > 57 && n < 63, 1'b1);
        host.wr(`VRC_OP_TRACK);
        host.idle;
        host.wr(4'h1);
        host.idle;
        host.wr(4'h4);
        host.idle;
        host.wr(`VRC_OP_ERASE);
        span(0, n);
        check(n > 27 && n < 33, 1'b1);
        $display("reset and erase done");
        print_verdict;
    end
endmodule // tb_vrc_cmd_port
